// *** src/ddasl_axis.sv ***
// One motion axis: DDA pulse generator, position counters, P loop, events
// Function
// - Command and actual positions and the compare value are signed 32-bit.
// - Local input, index, compare match and timer events each have an enable.
// - A move latches its signed count and period and holds them until done.
// - Exactly the commanded pulses are spread evenly over the period.
// - Pulses leave as quadrature, dual-line step or step plus direction.
// - Encoder inputs are filtered before being counted or used by the loop.
// - With the loop on, an error counter adds DDA pulses and subtracts feedback.
// - The DAC code is the gain times the error count, clamped to the signed DAC range.
// - With the loop off, the host writes the DAC code directly.
// - With the loop off, the encoder count is available to the host.
// - With the loop on, host DAC writes and the host encoder count are blocked.
// - Encoder input is quadrature at x1, x2 or x4, or up/down pulses.
// - A move takes a count from zero to the 28-bit maximum.
`timescale 1ns/1ns
`include "ddasl_map.svh"
module ddasl_axis #(
  parameter int FILT_LEN = `DDASL_FILT_LEN,
  parameter int DAC_W    = `DDASL_DAC_W,
  parameter int GAIN_W   = `DDASL_GAIN_W
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Move command
  input  wire logic                        move_load,
  input  wire logic                        move_neg,
  input  wire logic [`DDASL_CNT_W-1:0]     move_count,
  input  wire logic [`DDASL_PRD_W-1:0]     distribution_period,
  output logic                             move_busy,
  output logic                             move_done,
  output logic                             move_reject,
  // Pulse output
  input  wire logic [1:0]                  step_format,
  output logic                             step_a,
  output logic                             step_b,
  // Encoder input
  input  wire logic                        enc_a,
  input  wire logic                        enc_b,
  input  wire logic                        enc_index,
  input  wire logic                        enc_updown,
  input  wire logic [1:0]                  enc_mult,
  // Closed loop and DAC
  input  wire logic                        loop_enable,
  input  wire logic signed [GAIN_W-1:0]    gain,
  input  wire logic                        host_dac_wr,
  input  wire logic [DAC_W-1:0]            host_dac_data,
  output logic [DAC_W-1:0]                 dac_code,
  output logic                             host_dac_refused,
  // Positions
  input  wire logic signed [`DDASL_POS_W-1:0] cmp_value,
  output logic signed [`DDASL_POS_W-1:0]   cmd_pos,
  output logic signed [`DDASL_POS_W-1:0]   act_pos,
  output logic signed [`DDASL_POS_W-1:0]   following_err,
  output logic signed [`DDASL_POS_W-1:0]   handwheel_pulse_source,
  // Interrupt sources
  input  wire logic                        local_in,
  input  wire logic [`DDASL_PRD_W-1:0]     timer_period,
  input  wire logic [`DDASL_IRQ_N-1:0]     irq_enable,
  input  wire logic [`DDASL_IRQ_N-1:0]     irq_clear,
  output logic [`DDASL_IRQ_N-1:0]          irq_flags,
  output logic                             irq
);

  localparam int PW = `DDASL_POS_W;
  localparam int TW = `DDASL_PRD_W;
  localparam int MW = PW + GAIN_W;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clamp a wide product to the signed DAC range
  function automatic logic [DAC_W-1:0] sat_dac(
    input logic signed [MW-1:0] v
  );
    logic signed [MW-1:0] hi;
    logic signed [MW-1:0] lo;
    hi = MW'((64'sd1 <<< (DAC_W - 1)) - 64'sd1);
    lo = -hi - MW'(1);
    if (v > hi) sat_dac = hi[DAC_W-1:0];
    else if (v < lo) sat_dac = lo[DAC_W-1:0];
    else sat_dac = v[DAC_W-1:0];
  endfunction : sat_dac

  // Signed +1, -1 or 0 for an up/down pair of pulses
  function automatic logic signed [PW-1:0] delta(
    input logic up,
    input logic dn
  );
    delta = (up && !dn) ? PW'(1) : (dn && !up) ? -PW'(1) : PW'(0);
  endfunction : delta

  ////////////////////////////////////////////////////////////////////////////
  // Encoder front end

  ddasl_enc_if enc_ev ();

  ddasl_enc #(
    .FILT_LEN (FILT_LEN)
  ) u_enc (
    .clk        (clk),
    .nrst       (nrst),
    .enc_a      (enc_a),
    .enc_b      (enc_b),
    .enc_index  (enc_index),
    .enc_updown (enc_updown),
    .enc_mult   (enc_mult),
    .ev         (enc_ev.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Move sequencer and DDA accumulator

  ddasl_pkg::ddasl_state_e     state_q;
  logic [`DDASL_CNT_W-1:0]     cnt_q;
  logic                        neg_q;
  logic [TW-1:0]               prd_q;
  logic [TW-1:0]               elap_q;
  logic [TW:0]                 acc_q;
  logic [TW:0]                 acc_sum;
  logic                        idle;
  logic                        load_ok;
  logic                        dda_step;
  logic                        last_cyc;
  logic                        busy_q;
  logic                        done_q;
  logic                        rej_q;

  assign idle     = (state_q == ddasl_pkg::ST_IDLE);
  // Zero to full 28-bit count accepted; at most one pulse per clock
  assign load_ok  = (distribution_period != '0) &&
                    ({4'h0, move_count} <= distribution_period);
  assign acc_sum  = acc_q + {{(TW + 1 - `DDASL_CNT_W){1'b0}}, cnt_q};
  // Overflow of the accumulator marks the next pulse
  assign dda_step = !idle && (acc_sum >= {1'b0, prd_q});
  assign last_cyc = !idle && (elap_q == prd_q - TW'(1));

  // Count and period are held from load until the last cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ddasl_pkg::ST_IDLE;
      cnt_q   <= '0;
      neg_q   <= 1'b0;
      prd_q   <= '0;
      elap_q  <= '0;
      acc_q   <= '0;
    end else if (idle) begin
      if (move_load && load_ok) begin
        state_q <= ddasl_pkg::ST_RUN;
        cnt_q   <= move_count;
        neg_q   <= move_neg;
        prd_q   <= distribution_period;
        elap_q  <= '0;
        acc_q   <= '0;
      end
    end else begin
      acc_q  <= dda_step ? acc_sum - {1'b0, prd_q} : acc_sum;
      elap_q <= elap_q + TW'(1);
      if (last_cyc) state_q <= ddasl_pkg::ST_IDLE;
    end
  end

  // Status pulses; loads while running are ignored silently
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rej_q  <= 1'b0;
    end else begin
      busy_q <= !(idle || last_cyc) || (idle && move_load && load_ok);
      done_q <= last_cyc;
      rej_q  <= idle && move_load && !load_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse output encoder

  ddasl_pkg::ddasl_fmt_e fmt;
  logic [1:0]            phase_q;
  logic                  sa_q;
  logic                  sb_q;
  logic [1:0]            phase_d;
  logic                  sa_d;
  logic                  sb_d;

  assign fmt     = ddasl_pkg::ddasl_fmt_e'(step_format);
  assign phase_d = !dda_step ? phase_q :
                   neg_q ? phase_q - 2'h1 : phase_q + 2'h1;

  // Format select
  always_comb begin
    case (fmt)
      ddasl_pkg::FMT_QUAD: begin
        sa_d = phase_d[1] ^ phase_d[0]; // Gray sequence, A leads when +
        sb_d = phase_d[1];
      end
      ddasl_pkg::FMT_DUAL: begin
        sa_d = dda_step && !neg_q; // dual_line_step_format
        sb_d = dda_step && neg_q;
      end
      ddasl_pkg::FMT_PDIR: begin
        sa_d = dda_step;
        sb_d = !neg_q; // High level means positive direction
      end
      default: begin
        sa_d = 1'b0;
        sb_d = 1'b0;
      end
    endcase
  end

  // Registered so the pins never glitch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 2'h0;
      sa_q    <= 1'b0;
      sb_q    <= 1'b0;
    end else begin
      phase_q <= phase_d;
      sa_q    <= sa_d;
      sb_q    <= sb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position, host count and error counters

  logic signed [PW-1:0] cmd_q;
  logic signed [PW-1:0] act_q;
  logic signed [PW-1:0] host_cnt_q;
  logic signed [PW-1:0] err_q;
  logic signed [PW-1:0] cmd_dv;
  logic signed [PW-1:0] fb_dv;
  logic signed [PW-1:0] act_d;
  logic                 fb_any;

  assign cmd_dv = delta(dda_step && !neg_q, dda_step && neg_q);
  assign fb_dv  = delta(enc_ev.up, enc_ev.dn);
  assign fb_any = enc_ev.up ^ enc_ev.dn;
  assign act_d  = act_q + fb_dv;

  // Signed 32-bit counters wrap at the range ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q      <= `DDASL_POS_RESET;
      act_q      <= `DDASL_POS_RESET;
      host_cnt_q <= `DDASL_POS_RESET;
      err_q      <= `DDASL_POS_RESET;
    end else begin
      cmd_q <= cmd_q + cmd_dv;
      act_q <= act_d;
      // Host copy frozen while the loop owns the encoder
      if (!loop_enable) host_cnt_q <= host_cnt_q + fb_dv;
      // Error cleared while the loop is off, so enabling starts at zero
      err_q <= loop_enable ? err_q + cmd_dv - fb_dv : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Velocity command and DAC ownership

  logic signed [MW-1:0] vel_prod;
  logic [DAC_W-1:0]     dac_q;
  logic                 refused_q;

  assign vel_prod = MW'(err_q) * MW'(gain);

  // Loop output wins; a host write only lands with the loop off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dac_q     <= DAC_W'(`DDASL_DAC_RESET);
      refused_q <= 1'b0;
    end else begin
      if (loop_enable) dac_q <= sat_dac(vel_prod);
      else if (host_dac_wr) dac_q <= host_dac_data;
      refused_q <= loop_enable && host_dac_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources

  logic [TW-1:0]              tmr_q;
  logic                       local_prev_q;
  logic [`DDASL_IRQ_N-1:0]    ev_vec;
  logic [`DDASL_IRQ_N-1:0]    flag_q;
  logic                       irq_q;
  logic                       tmr_hit;

  // Timer disabled with a zero period
  assign tmr_hit = (timer_period != '0) && (tmr_q >= timer_period - TW'(1));

  always_comb begin
    ev_vec = '0;
    ev_vec[`DDASL_IRQ_LOCAL] = local_in && !local_prev_q;
    ev_vec[`DDASL_IRQ_INDEX] = enc_ev.idx;
    ev_vec[`DDASL_IRQ_CMP]   = fb_any && (act_d == cmp_value);
    ev_vec[`DDASL_IRQ_TIMER] = tmr_hit;
  end

  // Set beats clear, so an event in the clear cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmr_q        <= '0;
      local_prev_q <= 1'b0;
      flag_q       <= '0;
      irq_q        <= 1'b0;
    end else begin
      tmr_q        <= tmr_hit ? '0 : tmr_q + TW'(1);
      local_prev_q <= local_in;
      flag_q <= (flag_q & ~irq_clear) | (ev_vec & irq_enable);
      irq_q  <= |((flag_q & ~irq_clear) | (ev_vec & irq_enable));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign move_busy              = busy_q;
  assign move_done              = done_q;
  assign move_reject            = rej_q;
  assign step_a                 = sa_q;
  assign step_b                 = sb_q;
  assign dac_code               = dac_q;
  assign host_dac_refused       = refused_q;
  assign cmd_pos                = cmd_q;
  assign act_pos                = act_q;
  assign following_err          = err_q;
  assign handwheel_pulse_source = host_cnt_q;
  assign irq_flags              = flag_q;
  assign irq                    = irq_q;

endmodule : ddasl_axis

// *** src/ddasl_map.svh ***
// Constants for the per-axis pulse generator and servo loop
`ifndef DDASL_MAP_SVH
`define DDASL_MAP_SVH

// Data widths
`define DDASL_POS_W      32
`define DDASL_CNT_W      28
`define DDASL_PRD_W      32
`define DDASL_DAC_W      16
`define DDASL_GAIN_W     16

// Largest pulse count of one move
`define DDASL_MAX_COUNT  28'hFFFFFFF

// Encoder input filter: cycles a level must stay stable
`define DDASL_FILT_LEN   4

// Interrupt flag positions
`define DDASL_IRQ_N      4
`define DDASL_IRQ_LOCAL  0
`define DDASL_IRQ_INDEX  1
`define DDASL_IRQ_CMP    2
`define DDASL_IRQ_TIMER  3

// Reset values
`define DDASL_DAC_RESET  16'h0000
`define DDASL_POS_RESET  32'h00000000

`endif

// *** src/ddasl_pkg.sv ***
// Types shared by the pulse generator, encoder front end and loop
package ddasl_pkg;

  // Output pulse encodings
  typedef enum logic [1:0] {
    FMT_QUAD,
    FMT_DUAL,
    FMT_PDIR
  } ddasl_fmt_e;

  // Quadrature count multiplication
  typedef enum logic [1:0] {
    MULT_X1,
    MULT_X2,
    MULT_X4
  } ddasl_mult_e;

  // Move sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } ddasl_state_e;

endpackage : ddasl_pkg

// *** src/ddasl_enc_if.sv ***
// Filtered encoder events passed from the front end to the axis core
`timescale 1ns/1ns
interface ddasl_enc_if;
  logic up;
  logic dn;
  logic idx;

  modport src (output up, output dn, output idx);
  modport snk (input up, input dn, input idx);
endinterface : ddasl_enc_if

// *** src/ddasl_enc.sv ***
// Encoder front end: input filter and quadrature or up/down decoder
`timescale 1ns/1ns
`include "ddasl_map.svh"
module ddasl_enc #(
  parameter int FILT_LEN = `DDASL_FILT_LEN
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Raw encoder pins
  input  wire logic       enc_a,
  input  wire logic       enc_b,
  input  wire logic       enc_index,
  // Decoder setup
  input  wire logic       enc_updown,
  input  wire logic [1:0] enc_mult,
  // Filtered events
  ddasl_enc_if.src        ev
);

  localparam int FW = $clog2(FILT_LEN + 1);

  logic [2:0]    raw;
  logic [2:0]    cand_q;
  logic [2:0]    filt_q;
  logic [2:0]    prev_q;
  logic [FW-1:0] stab_q [3];
  logic          a_chg;
  logic          b_chg;
  logic          a_rise;
  logic          b_rise;
  logic          fwd;
  logic          qcnt;
  ddasl_pkg::ddasl_mult_e mult;

  assign raw  = {enc_index, enc_b, enc_a};
  assign mult = ddasl_pkg::ddasl_mult_e'(enc_mult);

  ////////////////////////////////////////////////////////////////////////////
  // Glitch filter: a level passes only once stable for FILT_LEN cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cand_q <= 3'h0;
      filt_q <= 3'h0;
      prev_q <= 3'h0;
      for (int i = 0; i < 3; i++) stab_q[i] <= '0;
    end else begin
      cand_q <= raw;
      prev_q <= filt_q;
      for (int i = 0; i < 3; i++) begin
        if (raw[i] != cand_q[i]) begin
          stab_q[i] <= '0;
        end else if (stab_q[i] == FW'(FILT_LEN - 1)) begin
          filt_q[i] <= cand_q[i];
        end else begin
          stab_q[i] <= stab_q[i] + FW'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding on filtered levels only
  assign a_chg  = filt_q[0] ^ prev_q[0];
  assign b_chg  = filt_q[1] ^ prev_q[1];
  assign a_rise = filt_q[0] & ~prev_q[0];
  assign b_rise = filt_q[1] & ~prev_q[1];
  assign fwd    = filt_q[0] ^ prev_q[1]; // A leading B counts up
  // Multiplier picks which edges count
  assign qcnt   = (mult == ddasl_pkg::MULT_X4) ? (a_chg | b_chg) :
                  (mult == ddasl_pkg::MULT_X2) ? a_chg : a_rise;

  // Up/down mode uses A as up and B as down pulse lines
  assign ev.up  = enc_updown ? (a_rise & ~b_rise) : (qcnt & fwd);
  assign ev.dn  = enc_updown ? (b_rise & ~a_rise) : (qcnt & ~fwd);
  assign ev.idx = filt_q[2] & ~prev_q[2];

endmodule : ddasl_enc

// *** sim/ddasl_props.sv ***
// Concurrent checks on the axis core ports
`timescale 1ns/1ns
`include "ddasl_map.svh"
module ddasl_props #(
  parameter int DAC_W  = 16,
  parameter int GAIN_W = 16
) (
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          nrst,
  // Move command
  input wire logic                          move_load,
  input wire logic [`DDASL_CNT_W-1:0]       move_count,
  input wire logic [`DDASL_PRD_W-1:0]       distribution_period,
  input wire logic                          move_busy,
  input wire logic                          move_done,
  input wire logic                          move_reject,
  // Loop and DAC
  input wire logic                          loop_enable,
  input wire logic signed [GAIN_W-1:0]      gain,
  input wire logic                          host_dac_wr,
  input wire logic [DAC_W-1:0]              host_dac_data,
  input wire logic [DAC_W-1:0]              dac_code,
  input wire logic                          host_dac_refused,
  input wire logic signed [`DDASL_POS_W-1:0] following_err,
  input wire logic signed [`DDASL_POS_W-1:0] handwheel_pulse_source,
  // Interrupts
  input wire logic                          local_in,
  input wire logic [`DDASL_IRQ_N-1:0]       irq_enable,
  input wire logic [`DDASL_IRQ_N-1:0]       irq_flags,
  input wire logic                          irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  localparam longint MX = (longint'(1) <<< (DAC_W - 1)) - 1;
  localparam longint MN = -MX - 1;
  logic [31:0] prd_q;
  logic [31:0] bcnt_q;
  // Full-scale clamp, so a big error never wraps the code
  function automatic logic [DAC_W-1:0] sat(input longint v);
    if (v > MX) return MX[DAC_W-1:0];
    if (v < MN) return MN[DAC_W-1:0];
    return v[DAC_W-1:0];
  endfunction : sat
  // Period of the taken move and cycles spent busy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prd_q  <= '0;
      bcnt_q <= '0;
    end else begin
      if (move_load && !move_busy) prd_q <= distribution_period;
      bcnt_q <= move_busy ? bcnt_q + 32'h1 : 32'h0;
    end
  end
  a_load_starts_busy: assert property (
    move_load && !move_busy && distribution_period != 0 &&
    move_count <= distribution_period |=> move_busy)
    else $error("good load not taken");
  a_bad_load_reject: assert property (
    move_load && !move_busy && (distribution_period == 0 ||
    move_count > distribution_period) |=> move_reject && !move_busy)
    else $error("bad load not refused");
  a_busy_period_len: assert property (
    $fell(move_busy) |-> bcnt_q == prd_q && move_done)
    else $error("busy length differs from period");
  a_dac_host_write: assert property (
    !loop_enable && host_dac_wr |=> dac_code == $past(host_dac_data))
    else $error("host DAC write lost");
  a_dac_host_block: assert property (
    loop_enable && host_dac_wr |=> host_dac_refused)
    else $error("host DAC write not refused");
  a_wheel_frozen_on: assert property (
    $past(loop_enable) |-> $stable(handwheel_pulse_source))
    else $error("host count moved with loop on");
  a_err_clear_off: assert property (
    !loop_enable && !$past(loop_enable) |-> following_err == 0)
    else $error("error counter not clear");
  a_dac_gain_sat: assert property (
    loop_enable && $past(loop_enable) |-> dac_code ==
    sat(longint'($past(following_err)) * longint'($past(gain))))
    else $error("DAC code not clamped gain times error");
  a_local_flag_set: assert property (
    $rose(local_in) && irq_enable[0] |-> ##[1:3] irq_flags[0])
    else $error("local event flag missing");
  a_flag_needs_enab: assert property (
    $rose(irq_flags[0]) |-> $past(irq_enable[0]))
    else $error("masked local flag set");
  a_irq_or_flags: assert property (
    irq_flags != 0 |-> irq)
    else $error("irq low with flag set");
endmodule : ddasl_props

bind ddasl_axis ddasl_props #(.DAC_W(DAC_W), .GAIN_W(GAIN_W)) ddasl_props_i (
  .clk, .nrst, .move_load, .move_count, .distribution_period, .move_busy,
  .move_done, .move_reject, .loop_enable, .gain, .host_dac_wr,
  .host_dac_data, .dac_code, .host_dac_refused, .following_err,
  .handwheel_pulse_source, .local_in, .irq_enable, .irq_flags, .irq);

// *** sim/ddasl_motor.sv ***
// Behavioural motor driver and encoder on the far side of the pulse pins
`timescale 1ns/1ns
module ddasl_motor (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Pulse pins and controls
  input  wire logic [1:0]    step_format,
  input  wire logic          step_a,
  input  wire logic          step_b,
  input  wire logic          ud_mode,
  input  wire logic          stall,
  // Encoder pins and shaft position
  output logic               enc_a,
  output logic               enc_b,
  output logic signed [31:0] shaft
);
  logic       a_q, b_q, chg, up, dn;
  logic [2:0] ua_q, db_q;
  // Step decode; a stalled shaft ignores steps
  assign chg = (step_a ^ a_q) | (step_b ^ b_q);
  assign up  = !stall && ((step_format == 2'h0) ? chg && (step_a ^ b_q) :
               (step_format == 2'h1) ? step_a : step_a && step_b);
  assign dn  = !stall && ((step_format == 2'h0) ? chg && !(step_a ^ b_q) :
               (step_format == 2'h1) ? step_b : step_a && !step_b);
  // Gray code from shaft, or stretched pulses so the filter passes them
  assign enc_a = ud_mode ? (ua_q != 3'h0) : shaft[0] ^ shaft[1];
  assign enc_b = ud_mode ? (db_q != 3'h0) : shaft[1];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_q   <= 1'b0;
      b_q   <= 1'b0;
      ua_q  <= 3'h0;
      db_q  <= 3'h0;
      shaft <= '0;
    end else begin
      a_q   <= step_a;
      b_q   <= step_b;
      ua_q  <= up ? 3'h6 : ua_q - {2'h0, ua_q != 3'h0};
      db_q  <= dn ? 3'h6 : db_q - {2'h0, db_q != 3'h0};
      shaft <= shaft + (up ? 32'sh1 : 32'sh0) - (dn ? 32'sh1 : 32'sh0);
    end
  end
endmodule : ddasl_motor

// *** sim/tb_top.sv ***
// Self-checking bench for one motion axis with its motor model
`timescale 1ns/1ns
`include "ddasl_map.svh"
module tb_top;
  logic clk, nrst, move_load, move_neg, move_busy, move_done, move_reject;
  logic step_a, step_b, enc_a, enc_b, enc_index, enc_updown, stall;
  logic loop_enable, host_dac_wr, host_dac_refused, local_in, irq;
  logic [27:0] move_count;
  logic [31:0] distribution_period, timer_period;
  logic [1:0]  step_format, enc_mult;
  logic signed [15:0] gain;
  logic [15:0] host_dac_data, dac_code;
  logic signed [31:0] cmp_value, cmd_pos, act_pos, following_err, shaft;
  logic signed [31:0] handwheel_pulse_source, c0, s0, a0, h0;
  logic [3:0]  irq_enable, irq_clear, irq_flags;
  int fails, total_checks, gap, i;
  int gaps[$];
  ddasl_axis #(.FILT_LEN(2)) ddasl_axis_i (.clk, .nrst, .move_load,
    .move_neg, .move_count, .distribution_period, .move_busy, .move_done,
    .move_reject, .step_format, .step_a, .step_b, .enc_a, .enc_b,
    .enc_index, .enc_updown, .enc_mult, .loop_enable, .gain, .host_dac_wr,
    .host_dac_data, .dac_code, .host_dac_refused, .cmp_value, .cmd_pos,
    .act_pos, .following_err, .handwheel_pulse_source, .local_in,
    .timer_period, .irq_enable, .irq_clear, .irq_flags, .irq);
  ddasl_motor ddasl_motor_i (.clk, .nrst, .step_format, .step_a, .step_b,
    .ud_mode(enc_updown), .stall, .enc_a, .enc_b, .shaft);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulse spacing, sampled mid-cycle where pins are settled
  always @(negedge clk) begin
    gap = gap + 1;
    if (step_a === 1'b1 && step_format != 2'h0) begin
      gaps.push_back(gap);
      gap = 0;
    end
  end
  task finish_test;
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Inputs change a fixed 5 ns after the rising edge
  task step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step
  task move(input logic neg, input logic [27:0] n, input logic [31:0] p,
            input logic bad);
    move_neg = neg;
    move_count = n;
    distribution_period = p;
    move_load = 1'b1;
    step(1);
    move_load = 1'b0;
    check("load", {move_busy, move_reject}, bad ? 1 : 2);
    if (bad) begin
      step(1); // Let an edge pass before the next load
      return;
    end
    for (i = 0; i <= p + 4 && move_done !== 1'b1; i++) step(1);
    if (move_done !== 1'b1) begin
      fails++;
      finish_test;
    end
    step(12); // Filter and counter pipeline settle
  endtask : move
  task dac_wr(input logic [15:0] d);
    host_dac_data = d;
    host_dac_wr = 1'b1;
    step(1);
    host_dac_wr = 1'b0;
  endtask : dac_wr
  task clear_irq;
    irq_clear = 4'hF;
    step(1);
    irq_clear = 4'h0;
    step(1);
  endtask : clear_irq
  initial begin
    {nrst, move_load, move_neg, enc_index, enc_updown, stall} = '0;
    {loop_enable, host_dac_wr, local_in, move_count} = '0;
    {distribution_period, timer_period, step_format, gain} = '0;
    {host_dac_data, irq_enable, irq_clear} = '0;
    {fails, total_checks, gap} = '0;
    enc_mult = 2'h2;
    cmp_value = 32'sh7FFFFFFF;
    repeat (6) @(posedge clk);
    #5 nrst = 1'b1;
    // Every output format, even spacing, filtered x4 feedback
    for (int f = 0; f < 3; f++) begin
      step_format = f[1:0];
      {c0, s0, a0} = {cmd_pos, shaft, act_pos};
      gaps.delete();
      move(1'b0, 8, 128, 1'b0);
      check("cmd_pos", cmd_pos - c0, 8);
      check("shaft", shaft - s0, 8);
      check("act_pos", act_pos - a0, 8);
      if (f != 0) check("pulses", gaps.size(), 8);
      foreach (gaps[k]) if (k > 0) check("gap", gaps[k], 16);
    end
    {c0, s0} = {cmd_pos, shaft};
    move(1'b1, 4, 64, 1'b0);
    check("cmd_neg", cmd_pos - c0, -4);
    check("shaft_neg", shaft - s0, -4);
    // Empty move, then refused loads
    c0 = cmd_pos;
    move(1'b0, 0, 8, 1'b0);
    check("cmd_zero", cmd_pos - c0, 0);
    move(1'b0, `DDASL_MAX_COUNT, 32'h0FFFFFFE, 1'b1);
    move(1'b0, 4, 0, 1'b1);
    // Host count at each multiplier, then up/down pulses
    for (int m = 0; m < 3; m++) begin
      enc_mult = m[1:0];
      h0 = handwheel_pulse_source;
      move(1'b0, 8, 128, 1'b0);
      check("wheel", handwheel_pulse_source - h0, 2 << m);
    end
    enc_updown = 1'b1;
    h0 = handwheel_pulse_source;
    move(1'b1, 4, 64, 1'b0);
    check("wheel_ud", handwheel_pulse_source - h0, -4);
    enc_updown = 1'b0;
    enc_mult = 2'h2;
    // Direct DAC with loop off
    dac_wr(16'h1234);
    check("dac_host", {host_dac_refused, dac_code}, 32'h1234);
    // Closed loop against a stalled shaft
    {stall, loop_enable, gain} = {2'b11, 16'sh3};
    step(2);
    h0 = handwheel_pulse_source;
    dac_wr(16'h4321);
    check("dac_refused", host_dac_refused, 1);
    move(1'b0, 8, 128, 1'b0);
    check("err", following_err, 8);
    check("dac_loop", dac_code, 24);
    gain = 16'sh7FFF;
    step(3);
    check("dac_pos_sat", dac_code, 16'h7FFF);
    gain = 16'sh8000;
    step(3);
    check("dac_neg_sat", dac_code, 16'h8000);
    // Shaft free again, so the encoder moves while the loop owns it
    stall = 1'b0;
    move(1'b0, 8, 128, 1'b0);
    check("wheel_frozen", handwheel_pulse_source, h0);
    check("err_track", following_err, 8);
    loop_enable = 1'b0;
    step(2);
    check("err_off", following_err, 0);
    // Interrupt sources, enables and clearing
    irq_enable = 4'h1;
    local_in = 1'b1;
    step(4);
    check("local", {irq, irq_flags}, 5'h11);
    local_in = 1'b0;
    clear_irq;
    check("cleared", {irq, irq_flags}, 0);
    irq_enable = 4'h0;
    local_in = 1'b1;
    step(4);
    check("masked", irq_flags, 0);
    {local_in, irq_enable, enc_index} = {1'b0, 4'h2, 1'b1};
    step(1);
    enc_index = 1'b0;
    step(6);
    check("glitch", irq_flags, 0);
    enc_index = 1'b1;
    step(6);
    enc_index = 1'b0;
    step(2);
    check("index", irq_flags, 4'h2);
    clear_irq;
    irq_enable = 4'h4;
    cmp_value = act_pos + 32'sh2;
    move(1'b0, 4, 64, 1'b0);
    check("compare", irq_flags, 4'h4);
    clear_irq;
    {irq_enable, timer_period} = {4'h8, 32'd20};
    for (i = 0; i < 60 && irq_flags[3] !== 1'b1; i++) step(1);
    check("timer", irq_flags[3], 1);
    finish_test;
  end
endmodule : tb_top
